/* File: flash_dev_model.sv */
// behavioural flash device answering the controller strobes
`timescale 1ns/10ps
module flash_dev_model #(
  parameter logic [7:0] COMPAT_ID = 8'h3c,
  parameter logic [7:0] DEVICE_CODE = 8'hc3,
  parameter logic [7:0] DEVICE_HI = 8'h5a,
  parameter int BUSY_READS = 2
) (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic byte_n,
  input wire logic rp_n,
  input wire logic vpp,
  input wire logic [19:0] addr,
  input wire logic [15:0] dq_in,
  input wire logic force_fail,
  input wire logic id_override,
  output logic [15:0] dq_out,
  output logic [15:0] dq_drv
);
  typedef enum logic [1:0] {MODE_ARRAY, MODE_ID, MODE_STAT} mode_t;
  mode_t mode = MODE_ARRAY;
  logic [7:0] sr = 8'h80;
  logic [7:0] sr_lat = 8'h80;
  logic [1:0] pend = 2'd0;
  logic [15:0] mem [16];
  int busy = 0;
  wire wr_n = ce_n | we_n;
  wire rd_n = ce_n | oe_n;
  initial foreach (mem[i]) mem[i] = 16'hffff;
  // reset pin restores array mode and clears status
  always @(negedge rp_n)
  begin
    mode = MODE_ARRAY;
    sr = 8'h80;
    pend = 2'd0;
  end
  task automatic start_op(input logic erase);
    mode = MODE_STAT;
    // supply fail refuses writes and erases
    if (sr[3]) return;
    // supply sampled at the data or confirm write, forced retry exhaustion
    if (!vpp) sr[3] = 1'b1;
    else if (force_fail) sr[erase ? 5 : 4] = 1'b1;
    else if (erase) foreach (mem[i]) mem[i] = 16'hffff;
    else mem[addr[3:0]] &= dq_in;
    busy = BUSY_READS;
    sr[7] = 1'b0;
  endtask : start_op
  // capture on the first rising strobe
  always @(posedge wr_n)
  begin
    if (rp_n && pend != 2'd0)
    begin
      if (pend == 2'd1 || dq_in[7:0] == 8'hd0) start_op(pend == 2'd2);
      else sr[5:4] = 2'b11;
      pend = 2'd0;
      mode = MODE_STAT;
    end
    else if (rp_n)
    begin
      mode = MODE_STAT;
      // command decode, errors sticky until 50h
      case (dq_in[7:0])
        8'hff: mode = MODE_ARRAY;
        8'h90: mode = MODE_ID;
        8'h50: sr[5:3] = 3'b000;
        8'h40, 8'h10: pend = 2'd1;
        8'h20: pend = 2'd2;
        8'hb0: sr[7:6] = 2'b11;
        8'hd0: sr[6] = 1'b0;
        default: ;
      endcase
    end
  end
  // status frozen at the falling read strobe
  always @(negedge rd_n)
  begin
    if (busy > 0) busy = busy - 1;
    sr[7] = (busy == 0);
    sr_lat = sr;
  end
  // read data by mode, upper lanes float in byte mode
  // override shows id but leaves the mode untouched
  always_comb
  begin
    dq_out = {8'h00, sr_lat};
    if (id_override || mode == MODE_ID)
      dq_out = addr[0] ? {DEVICE_HI, DEVICE_CODE} : {8'h00, COMPAT_ID};
    else if (mode == MODE_ARRAY)
      dq_out = mem[addr[3:0]];
  end
  assign dq_drv = rd_n ? 16'h0000 : (byte_n ? 16'hffff : 16'h00ff);
endmodule : flash_dev_model

/* File: flash_host_ctrl.sv */
// host-side sequencer driving a parallel flash over its strobe pins
`timescale 1ns/10ps
module flash_host_ctrl (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic req_valid,
  input wire flash_host_pkg::req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output flash_host_pkg::rsp_t rsp,
  input wire logic byte_mode,
  input wire logic powerdown,
  input wire logic boot_unlock,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic flash_byte_n,
  output logic reset_powerdown_n,
  output logic flash_wp,
  output logic vpp_en,
  output logic [flash_host_pkg::ADDR_W-1:0] flash_addr,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic [15:0] dq_oe
);
  import flash_host_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_SETUP, S_PULSE, S_RECOVER} state_t;

  // only defined codes; one bus cycle per op and step
  function automatic cycle_t step_of(input op_t op, input logic [1:0] step);
    cycle_t c;
    c = '{rd: 1'b0, poll: 1'b0, last: 1'b0, array_data: 1'b0, code: CMD_READ_ARRAY};
    case (op)
      OP_READ_ARRAY:
      begin
        c.rd = (step != 2'd0);
        c.last = (step != 2'd0);
      end
      OP_READ_ID:
      begin
        c.code = CMD_IDENTIFY;
        c.rd = (step != 2'd0);
        c.last = (step != 2'd0);
      end
      OP_READ_STATUS:
      begin
        c.code = CMD_READ_STATUS;
        c.rd = (step != 2'd0);
        c.last = (step != 2'd0);
      end
      OP_CLEAR_STATUS:
      begin
        c.code = CMD_CLEAR_STATUS;
        c.last = 1'b1;
      end
      OP_PROGRAM:
      begin
        // setup always precedes the data cycle
        c.code = CMD_WRITE_SETUP;
        c.array_data = (step == 2'd1);
        c.rd = (step == 2'd2);
        c.poll = (step == 2'd2);
        c.last = (step == 2'd2);
      end
      OP_ERASE:
      begin
        c.code = (step == 2'd0) ? CMD_ERASE_SETUP : CMD_CONFIRM;
        c.rd = (step == 2'd2);
        c.poll = (step == 2'd2);
        c.last = (step == 2'd2);
      end
      OP_SUSPEND:
      begin
        c.code = CMD_SUSPEND;
        c.rd = (step == 2'd1);
        c.poll = (step == 2'd1);
        c.last = (step == 2'd1);
      end
      OP_RESUME:
      begin
        c.code = CMD_CONFIRM;
        c.last = 1'b1;
      end
      default:
      begin
        c.last = 1'b1;
      end
    endcase
    return c;
  endfunction : step_of

  state_t state_q;
  state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [1:0] step_q;
  logic [1:0] step_d;
  req_t req_q;
  logic array_mode_q;
  logic [15:0] rdata_q;
  logic [15:0] dq_sync;

  wire logic accept = req_valid && req_ready && (state_q == S_IDLE);
  wire cycle_t cur = step_of(req_q.op, step_q);
  wire logic cnt_zero = (cnt_q == '0);
  // polls rely on reads returning status with no command
  wire logic poll_again = cur.poll && !rdata_q[READY_BIT];
  wire logic finish = cur.last && !poll_again;
  wire logic cycle_end = (state_q == S_RECOVER) && cnt_zero;
  wire logic done = cycle_end && finish;
  // skip the FFh cycle when already in array read mode
  wire logic [1:0] start_step = (req.op == OP_READ_ARRAY && array_mode_q) ? 2'd1 : 2'd0;
  wire logic supply_op = (req_q.op == OP_PROGRAM) || (req_q.op == OP_ERASE)
                         || (req_q.op == OP_RESUME);
  wire logic active = (state_q == S_SETUP) || (state_q == S_PULSE);
  wire logic drive_bus = (state_q != S_IDLE) && !cur.rd;
  // byte mode: low lanes plus lane fifteen as lowest address
  wire logic [15:0] wr_data = !cur.array_data ? {8'h00, cur.code}
                              : byte_mode ? {req_q.addr[0], 7'h00, req_q.data[7:0]}
                              : req_q.data;
  wire logic [15:0] wr_lanes = !cur.array_data ? LANES_LOW
                               : byte_mode ? LANES_BYTE : LANES_WORD;
  // id and status arrive on the low byte only
  wire logic low_only = (req_q.op != OP_READ_ARRAY);
  wire logic [15:0] rd_value = low_only ? {8'h00, rdata_q[7:0]} : rdata_q;
  wire logic [7:0] last_status = cur.poll ? rdata_q[7:0] : 8'h00;
  // sticky error bits reported on polled ops until the user clears them
  wire logic err_seen = |last_status[ERASE_FAIL_BIT:SUPPLY_FAIL_BIT];

  pin_sync #(
    .W(16)
  ) u_dq_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .din(dq_i),
    .dout(dq_sync)
  );

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_zero ? cnt_q : cnt_q - 1'b1;
    step_d = step_q;
    case (state_q)
      S_IDLE:
      begin
        if (accept)
        begin
          state_d = S_SETUP;
          cnt_d = SETUP_CYC - 1'b1;
          step_d = start_step;
        end
      end
      S_SETUP:
      begin
        if (cnt_zero)
        begin
          state_d = S_PULSE;
          cnt_d = cur.rd ? RD_CYC - 1'b1 : WP_CYC - 1'b1;
        end
      end
      S_PULSE:
      begin
        // strobes rise together, so one capture edge per cycle
        if (cnt_zero)
        begin
          state_d = S_RECOVER;
          cnt_d = REC_CYC - 1'b1;
        end
      end
      S_RECOVER:
      begin
        if (cnt_zero)
        begin
          state_d = finish ? S_IDLE : S_SETUP;
          cnt_d = SETUP_CYC - 1'b1;
          // each poll is a fresh strobe cycle
          step_d = (finish || poll_again) ? step_q : step_q + 2'd1;
        end
      end
      default:
      begin
        state_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= S_IDLE;
      cnt_q <= '0;
      step_q <= '0;
      req_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      step_q <= step_d;
      if (accept)
      begin
        req_q <= req;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata_q <= '0;
    end
    else if (state_q == S_PULSE && cnt_zero && cur.rd)
    begin
      rdata_q <= dq_sync;
    end
  end

  // reset and powerdown leave the device in array read mode
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      array_mode_q <= 1'b1;
    end
    else if (powerdown)
    begin
      array_mode_q <= 1'b1;
    end
    else if (state_q == S_PULSE && cnt_zero && !cur.rd)
    begin
      array_mode_q <= !cur.array_data && (cur.code == CMD_READ_ARRAY);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp <= '0;
    end
    else
    begin
      req_ready <= (state_d == S_IDLE) && !accept;
      rsp_valid <= done;
      if (done)
      begin
        rsp <= '{data: rd_value, status: last_status, error: err_seen};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_byte_n <= 1'b1;
      reset_powerdown_n <= 1'b0;
      flash_wp <= 1'b0;
      vpp_en <= 1'b0;
      flash_addr <= '0;
      dq_o <= '0;
      dq_oe <= LANES_NONE;
    end
    else
    begin
      // select low in setup and pulse; one strobe at a time
      flash_ce_n <= !active;
      flash_oe_n <= !(state_q == S_PULSE && cur.rd);
      flash_we_n <= !(state_q == S_PULSE && !cur.rd);
      flash_byte_n <= !byte_mode;
      reset_powerdown_n <= !powerdown;
      // supply held through program, erase and resume; unlock pin follows boot_unlock every cycle
      flash_wp <= boot_unlock;
      vpp_en <= (state_q != S_IDLE) && supply_op;
      // request address stays on the pins for the whole sequence
      flash_addr <= req_q.addr[ADDR_W:1];
      dq_o <= wr_data;
      dq_oe <= drive_bus ? wr_lanes : LANES_NONE;
    end
  end

endmodule : flash_host_ctrl

/* File: flash_host_ctrl_sva.sv */
// port assertions for the flash host controller
`timescale 1ns/10ps
module flash_host_ctrl_sva (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire flash_host_pkg::rsp_t rsp,
  input wire logic byte_mode,
  input wire logic powerdown,
  input wire logic boot_unlock,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic flash_byte_n,
  input wire logic reset_powerdown_n,
  input wire logic flash_wp,
  input wire logic [15:0] dq_oe
);
  import flash_host_pkg::*;
  logic [CNT_W-1:0] we_cnt_q;
  logic [CNT_W-1:0] oe_cnt_q;
  // strobe low times, so pulse widths can be checked exactly
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      we_cnt_q <= '0;
      oe_cnt_q <= '0;
    end
    else
    begin
      we_cnt_q <= flash_we_n ? '0 : we_cnt_q + 1'b1;
      oe_cnt_q <= flash_oe_n ? '0 : oe_cnt_q + 1'b1;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_strobe_excl: assert property (flash_oe_n || flash_we_n)
    else $error("read and write strobes low together");
  a_write_select: assert property ($fell(flash_we_n) |-> !flash_ce_n && flash_oe_n)
    else $error("write strobe without select or with output drive");
  a_write_width: assert property ($rose(flash_we_n) |-> we_cnt_q == WP_CYC)
    else $error("write pulse width wrong");
  a_read_width: assert property ($rose(flash_oe_n) |-> oe_cnt_q == RD_CYC)
    else $error("read pulse width wrong");
  a_edge_together: assert property ($rose(flash_we_n) |-> $rose(flash_ce_n))
    else $error("select not released with write strobe");
  a_cmd_lanes: assert property (!flash_we_n |-> dq_oe[7:0] == 8'hff)
    else $error("low lanes not driven in write");
  a_byte_float: assert property (!flash_byte_n && !flash_we_n |-> dq_oe[14:8] == 7'h00)
    else $error("middle lanes driven in byte mode");
  a_byte_pin: assert property ($past(arst_n) |-> flash_byte_n == !$past(byte_mode))
    else $error("byte pin does not follow byte_mode");
  a_pd_pin: assert property ($past(arst_n) |-> reset_powerdown_n == !$past(powerdown))
    else $error("powerdown pin does not follow powerdown");
  a_wp_pin: assert property ($past(arst_n) |-> flash_wp == $past(boot_unlock))
    else $error("unlock pin does not follow boot_unlock");
  a_rsp_pulse: assert property (rsp_valid |-> req_ready ##1 !rsp_valid)
    else $error("response not a single pulse with ready");
  a_err_flag: assert property (rsp_valid |-> rsp.error == |rsp.status[5:3])
    else $error("error flag disagrees with status");
  a_take_busy: assert property (req_valid && req_ready |=> !req_ready [*2])
    else $error("ready stayed high after a request");
endmodule : flash_host_ctrl_sva
bind flash_host_ctrl flash_host_ctrl_sva chk (.clk_sys, .arst_n, .req_valid, .req_ready,
  .rsp_valid, .rsp, .byte_mode, .powerdown, .boot_unlock, .flash_ce_n, .flash_oe_n,
  .flash_we_n, .flash_byte_n, .reset_powerdown_n, .flash_wp, .dq_oe);

/* File: flash_host_pkg.sv */
// shared types, command codes and timing for the flash host controller
package flash_host_pkg;

  // clock rate and strobe timing
  localparam int CLK_MHZ = 250;
  localparam int T_SETUP_NS = 10;
  localparam int T_WP_NS = 50;
  localparam int T_ACC_NS = 80;
  localparam int T_REC_NS = 30;
  localparam int SYNC_LAT = 2;
  localparam int CNT_W = 8;

  // least times round up to whole cycles
  localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'((T_SETUP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] WP_CYC = CNT_W'((T_WP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] REC_CYC = CNT_W'((T_REC_NS * CLK_MHZ + 999) / 1000);
  // read strobe also covers the pin synchroniser and the output register
  localparam logic [CNT_W-1:0] RD_CYC = CNT_W'((T_ACC_NS * CLK_MHZ + 999) / 1000 + SYNC_LAT + 1);

  // command codes
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_IDENTIFY = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;

  // engine_status field positions
  localparam int READY_BIT = 7;
  localparam int SUSPEND_BIT = 6;
  localparam int ERASE_FAIL_BIT = 5;
  localparam int WRITE_FAIL_BIT = 4;
  localparam int SUPPLY_FAIL_BIT = 3;

  // pin lane masks
  localparam logic [15:0] LANES_NONE = 16'h0000;
  localparam logic [15:0] LANES_LOW = 16'h00ff;
  localparam logic [15:0] LANES_WORD = 16'hffff;
  localparam logic [15:0] LANES_BYTE = 16'h80ff;
  localparam int BYTE_ADDR_LANE = 15;

  localparam int ADDR_W = 20;

  typedef enum logic [2:0] {
    OP_READ_ARRAY,
    OP_READ_ID,
    OP_READ_STATUS,
    OP_CLEAR_STATUS,
    OP_PROGRAM,
    OP_ERASE,
    OP_SUSPEND,
    OP_RESUME
  } op_t;

  // addr[0] is the byte select in byte mode, addr[20:1] go to the address pins
  typedef struct packed {
    op_t op;
    logic [ADDR_W:0] addr;
    logic [15:0] data;
  } req_t;

  typedef struct packed {
    logic [15:0] data;
    logic [7:0] status;
    logic error;
  } rsp_t;

  // one bus cycle of a sequence
  typedef struct packed {
    logic rd;
    logic poll;
    logic last;
    logic array_data;
    logic [7:0] code;
  } cycle_t;

endpackage : flash_host_pkg

/* File: pin_sync.sv */
// two-flop synchroniser for pins read back from the flash
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 16
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_q <= '0;
      dout <= '0;
    end
    else
    begin
      meta_q <= din;
      dout <= meta_q;
    end
  end

endmodule : pin_sync

/* File: test_flash_host_ctrl.sv */
// directed test of the flash host controller against a device model
`timescale 1ns/10ps
module test_flash_host_ctrl;
  import flash_host_pkg::*;
  // identification values are arbitrary
  localparam logic [7:0] COMPAT = 8'h3c;
  localparam logic [7:0] DEVID = 8'hc3;
  logic clk_sys = 1'b0;
  logic arst_n, req_valid, req_ready, rsp_valid, byte_mode, powerdown, boot_unlock;
  logic flash_ce_n, flash_oe_n, flash_we_n, flash_byte_n, reset_powerdown_n;
  logic flash_wp, vpp_en, force_fail, id_override;
  logic [19:0] flash_addr;
  logic [15:0] dq_i, dq_o, dq_oe, dev_dq, dev_drv;
  logic [15:0] dq_last = 16'h0000;
  req_t req;
  rsp_t rsp;
  int err_count = 0;
  int checked = 0;
  initial forever #2 clk_sys = ~clk_sys;
  // undriven lanes flip every cycle so stale data never matches
  always @(posedge clk_sys) dq_last <= dq_i;
  assign dq_i = (dev_drv & dev_dq) | (~dev_drv & dq_oe & dq_o) | (~dev_drv & ~dq_oe & ~dq_last);
  flash_host_ctrl dut (.clk_sys, .arst_n, .req_valid, .req, .req_ready, .rsp_valid, .rsp,
    .byte_mode, .powerdown, .boot_unlock, .flash_ce_n, .flash_oe_n, .flash_we_n,
    .flash_byte_n, .reset_powerdown_n, .flash_wp, .vpp_en, .flash_addr, .dq_i, .dq_o, .dq_oe);
  flash_dev_model #(.COMPAT_ID(COMPAT), .DEVICE_CODE(DEVID)) dev (.ce_n(flash_ce_n),
    .oe_n(flash_oe_n), .we_n(flash_we_n), .byte_n(flash_byte_n), .rp_n(reset_powerdown_n),
    .vpp(vpp_en), .addr(flash_addr), .dq_in(dq_i), .force_fail, .id_override, .dq_out(dev_dq),
    .dq_drv(dev_drv));
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic do_op(input op_t op, input logic [20:0] a, input logic [15:0] d);
    int n;
    @(negedge clk_sys);
    req = '{op, a, d};
    req_valid = 1'b1;
    for (n = 0; n < 100 && req_ready !== 1'b1; n++)
      @(negedge clk_sys);
    if (n >= 100)
    begin
      err_count++;
      finish_test();
    end
    @(posedge clk_sys);
    @(negedge clk_sys);
    req_valid = 1'b0;
    for (n = 0; n < 20000 && rsp_valid !== 1'b1; n++)
      @(negedge clk_sys);
    if (n >= 20000)
    begin
      err_count++;
      finish_test();
    end
  endtask : do_op
  // polled ops are judged on status, reads on data
  task automatic run_chk(input op_t op, input logic [20:0] a, input logic [15:0] d,
                         input logic [15:0] exp);
    do_op(op, a, d);
    if (op inside {OP_PROGRAM, OP_ERASE, OP_SUSPEND})
      check("status", exp, {8'h00, rsp.status});
    else
      check("data", exp, rsp.data);
  endtask : run_chk
  initial
  begin
    arst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    byte_mode = 1'b0;
    powerdown = 1'b0;
    boot_unlock = 1'b1;
    force_fail = 1'b0;
    id_override = 1'b0;
    repeat (12) @(negedge clk_sys);
    arst_n = 1'b1;
    run_chk(OP_READ_ARRAY, 21'h4, 16'h0, 16'hffff);
    run_chk(OP_READ_ID, 21'h0, 16'h0, {8'h00, COMPAT});
    run_chk(OP_READ_ID, 21'h2, 16'h0, {8'h00, DEVID});
    run_chk(OP_PROGRAM, 21'h4, 16'h1234, 16'h0080);
    run_chk(OP_PROGRAM, 21'h4, 16'hff0f, 16'h0080);
    run_chk(OP_READ_ARRAY, 21'h4, 16'h0, 16'h1204);
    run_chk(OP_ERASE, 21'h4, 16'h0, 16'h0080);
    run_chk(OP_READ_ARRAY, 21'h4, 16'h0, 16'hffff);
    force_fail = 1'b1;
    run_chk(OP_PROGRAM, 21'h4, 16'h0f0f, 16'h0090);
    force_fail = 1'b0;
    check("error flag", 16'h0001, {15'h0, rsp.error});
    run_chk(OP_READ_STATUS, 21'h0, 16'h0, 16'h0090);
    do_op(OP_CLEAR_STATUS, 21'h0, 16'h0);
    run_chk(OP_READ_STATUS, 21'h0, 16'h0, 16'h0080);
    // override wins over status mode, then status mode is back
    id_override = 1'b1;
    run_chk(OP_READ_STATUS, 21'h0, 16'h0, {8'h00, COMPAT});
    id_override = 1'b0;
    run_chk(OP_READ_STATUS, 21'h0, 16'h0, 16'h0080);
    run_chk(OP_SUSPEND, 21'h0, 16'h0, 16'h00c0);
    do_op(OP_RESUME, 21'h0, 16'h0);
    run_chk(OP_READ_STATUS, 21'h0, 16'h0, 16'h0080);
    force_fail = 1'b1;
    run_chk(OP_ERASE, 21'h4, 16'h0, 16'h00a0);
    force_fail = 1'b0;
    powerdown = 1'b1;
    repeat (4) @(negedge clk_sys);
    powerdown = 1'b0;
    run_chk(OP_READ_STATUS, 21'h0, 16'h0, 16'h0080);
    byte_mode = 1'b1;
    boot_unlock = 1'b0;
    run_chk(OP_READ_ID, 21'h2, 16'h0, {8'h00, DEVID});
    finish_test();
  end
endmodule : test_flash_host_ctrl
